// ===== rtl/arh_pkg.sv
// shared constants and types of the analyzer remote handshake block
`default_nettype none
package arh_pkg;
	// ***************
	// timing
	// ***************
	localparam int CLK_HZ = 10_000_000;
	localparam int BAUD_RATE = 2400;
	localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
	localparam int MUX_DWELL_CYCLES = 1000;
	// ***************
	// widths and sizes
	// ***************
	localparam int DATA_BITS = 8;
	localparam int RECIPE_W = 3;
	localparam int PHYS_OUTS = 4;
	localparam int LOG_CHANS = 8;
	localparam int RESULT_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [RECIPE_W-1:0] RECIPE_MAX = 3'h7;
	// ***************
	// characters
	// ***************
	localparam logic [7:0] CHR_EOF = 8'h1A;
	localparam logic [7:0] CHR_START = 8'h61;
	localparam logic [7:0] CHR_IDENT = 8'h69;
	localparam logic [7:0] CHR_RESULTS = 8'h72;
	localparam logic [7:0] CHR_COMMA = 8'h2C;
	localparam logic [7:0] CHR_ZERO = 8'h30;
	localparam logic [7:0] CHR_NINE = 8'h39;
	// ***************
	// types
	// ***************
	typedef enum logic [1:0] {MODE_LOCAL, MODE_REMOTE, MODE_COMPUTER} arh_mode_type;
	typedef enum {ST_IDLE, ST_ANALYZE, ST_REFRESH, ST_REPORT, ST_DONE} arh_state_type;
	typedef enum {RPT_NONE, RPT_RESULTS, RPT_IDENT} arh_report_type;
	typedef enum {CMD_IDLE, CMD_COMMA, CMD_TENS, CMD_ONES} arh_cmd_type;
endpackage
`default_nettype wire

// ===== rtl/arh_stream_if.sv
// byte stream with valid and ready between the block's own modules
`default_nettype none
interface arh_stream_if #(parameter int W = 8) ();
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface
`default_nettype wire

// ===== rtl/arh_fifo.sv
// synchronous fifo with parameter width and depth
`default_nettype none
module arh_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	arh_stream_if.snk inS,
	arh_stream_if.src outS
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("fifo depth must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr;
	logic [AW:0] rdPtr;
	logic full;
	logic empty;
	assign full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	assign empty = (wrPtr == rdPtr);
	assign inS.ready = !full;
	assign outS.valid = !empty;
	assign outS.data = mem[rdPtr[AW-1:0]];
	always_ff @(posedge clk) begin
		if (inS.valid && !full) begin
			mem[wrPtr[AW-1:0]] <= inS.data;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (inS.valid && !full) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (outS.ready && !empty) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/arh_uart.sv
// serial port, 8 data bits, no parity, one stop bit
`default_nettype none
module arh_uart #(
	parameter int BIT_CYCLES = arh_pkg::BIT_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	arh_stream_if.snk txIn,
	input wire logic rxd,
	output logic txd,
	output logic [arh_pkg::DATA_BITS-1:0] rxData,
	output logic rxValid
);
	localparam int DB = arh_pkg::DATA_BITS;
	localparam int CW = $clog2(BIT_CYCLES + 1);
	localparam logic [3:0] FRAME = 4'(DB + 2);
	localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYCLES / 2);
	if (BIT_CYCLES < 4 || DB != 8) begin : g_chk
		$error("bit period too short or frame width unsupported");
	end
	logic [DB+1:0] txShift;
	logic [3:0] txBits;
	logic [CW-1:0] txBaud;
	logic [3:0] rxBits;
	logic [CW-1:0] rxBaud;
	// ***************
	// transmitter
	// ***************
	assign txIn.ready = (txBits == 4'h0);
	assign txd = txShift[0];
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txShift <= '1;
			txBits <= 4'h0;
			txBaud <= '0;
		end else if (txBits == 4'h0) begin
			if (txIn.valid) begin
				txShift <= {1'b1, txIn.data, 1'b0};
				txBits <= FRAME;
				txBaud <= BIT_LAST;
			end
		end else if (txBaud == '0) begin
			txShift <= {1'b1, txShift[DB+1:1]};
			txBits <= txBits - 4'h1;
			txBaud <= BIT_LAST;
		end else begin
			txBaud <= txBaud - 1'b1;
		end
	end
	// ***************
	// receiver
	// ***************
	// sampled at mid bit; a start bit gone high by then is taken as noise
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rxBits <= 4'h0;
			rxBaud <= '0;
			rxData <= '0;
			rxValid <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			if (rxBits == 4'h0) begin
				if (!rxd) begin
					rxBits <= FRAME;
					rxBaud <= BIT_HALF;
				end
			end else if (rxBaud == '0) begin
				rxBaud <= BIT_LAST;
				rxBits <= rxBits - 4'h1;
				if (rxBits == FRAME && rxd) begin
					rxBits <= 4'h0;
				end else if (rxBits == 4'h1) begin
					rxValid <= rxd;
				end else if (rxBits != FRAME) begin
					rxData <= {rxd, rxData[DB-1:1]};
				end
			end else begin
				rxBaud <= rxBaud - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/arh_remote_handshake.sv
// remote-control front end: start handshake, recipe select, analog hold, serial reports
`default_nettype none
module arh_remote_handshake #(
	parameter int BIT_CYCLES = arh_pkg::BIT_CYCLES,
	parameter int MUX_DWELL_CYCLES = arh_pkg::MUX_DWELL_CYCLES,
	parameter int FIFO_DEPTH = arh_pkg::FIFO_DEPTH,
	// identity byte: value is arbitrary
	parameter logic [7:0] IDENT_CODE = 8'h5A
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic startContact,
	input wire logic [arh_pkg::RECIPE_W-1:0] recipeContact,
	input wire arh_pkg::arh_mode_type opMode,
	input wire logic analysisDone,
	input wire logic [arh_pkg::LOG_CHANS-1:0][arh_pkg::RESULT_W-1:0] analysisResult,
	input wire logic rxd,
	output logic readyContact,
	output logic analysisReq,
	output logic [arh_pkg::RECIPE_W-1:0] analysisRecipe,
	output logic [arh_pkg::PHYS_OUTS-1:0][arh_pkg::RESULT_W-1:0] analogOut,
	output logic analogSlot,
	output logic txd
);
	localparam int LC = arh_pkg::LOG_CHANS;
	localparam int PO = arh_pkg::PHYS_OUTS;
	localparam int IW = $clog2(LC) + 1;
	localparam int MW = $clog2(MUX_DWELL_CYCLES + 1);
	localparam logic [IW-1:0] RES_LAST = IW'(LC);
	localparam logic [IW-1:0] ID_LAST = IW'(1);
	localparam logic [MW-1:0] MUX_LAST = MW'(MUX_DWELL_CYCLES - 1);
	if (LC != 2 * PO || MUX_DWELL_CYCLES < 1) begin : g_chk
		$error("channel count must be twice the outputs and dwell positive");
	end
	function automatic logic isDigit(input logic [7:0] c);
		return (c >= arh_pkg::CHR_ZERO) && (c <= arh_pkg::CHR_NINE);
	endfunction
	arh_pkg::arh_state_type state;
	arh_pkg::arh_state_type next_state;
	arh_pkg::arh_report_type rptKind;
	arh_pkg::arh_cmd_type cmdState;
	logic startPrev;
	logic startEdge;
	logic accept;
	logic [LC-1:0][arh_pkg::RESULT_W-1:0] resultHold;
	logic [IW-1:0] rptIdx;
	logic rptAuto;
	logic rptLast;
	logic rptEnd;
	logic launchAuto;
	logic launchRes;
	logic launchId;
	logic resPend;
	logic idPend;
	logic serialStart;
	logic [arh_pkg::RECIPE_W-1:0] cmdRecipe;
	logic [7:0] tensChar;
	logic [7:0] rxData;
	logic rxValid;
	logic [MW-1:0] muxCnt;
	arh_stream_if #(.W(8)) pushS ();
	arh_stream_if #(.W(8)) popS ();
	// ***************
	// start handshake
	// ***************
	// edge taken so a start held closed through the run does not retrigger
	assign startEdge = startContact && !startPrev;
	assign accept = (state == arh_pkg::ST_IDLE) && (startEdge || serialStart);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			startPrev <= 1'b0;
		end else begin
			startPrev <= startContact;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			arh_pkg::ST_IDLE: begin
				if (accept) begin
					next_state = arh_pkg::ST_ANALYZE;
				end
			end
			arh_pkg::ST_ANALYZE: begin
				if (analysisDone) begin
					next_state = arh_pkg::ST_REFRESH;
				end
			end
			arh_pkg::ST_REFRESH: begin
				if (opMode == arh_pkg::MODE_COMPUTER) begin
					next_state = arh_pkg::ST_DONE;
				end else begin
					next_state = arh_pkg::ST_REPORT;
				end
			end
			arh_pkg::ST_REPORT: begin
				if (rptEnd && rptAuto) begin
					next_state = arh_pkg::ST_DONE;
				end
			end
			arh_pkg::ST_DONE: begin
				next_state = arh_pkg::ST_IDLE;
			end
			default: begin
				next_state = arh_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= arh_pkg::ST_IDLE;
			readyContact <= 1'b1;
		end else begin
			state <= next_state;
			readyContact <= (next_state == arh_pkg::ST_IDLE);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			analysisReq <= 1'b0;
			analysisRecipe <= '0;
		end else begin
			analysisReq <= accept;
			if (accept) begin
				// all contacts open decodes to recipe 0, the default
				analysisRecipe <= serialStart ? cmdRecipe : recipeContact;
			end
		end
	end

	// ***************
	// result hold and analog outputs
	// ***************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resultHold <= '0;
		end else if (state == arh_pkg::ST_ANALYZE && analysisDone) begin
			resultHold <= analysisResult;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			muxCnt <= '0;
			analogSlot <= 1'b0;
		end else if (muxCnt == '0) begin
			muxCnt <= MUX_LAST;
			analogSlot <= !analogSlot;
		end else begin
			muxCnt <= muxCnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			analogOut <= '0;
		end else begin
			for (int k = 0; k < PO; k++) begin
				analogOut[k] <= analogSlot ? resultHold[k + PO] : resultHold[k];
			end
		end
	end

	// ***************
	// host command parser
	// ***************
	// upper case letters fall through as unknown and are dropped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmdState <= arh_pkg::CMD_IDLE;
			tensChar <= '0;
			cmdRecipe <= '0;
			serialStart <= 1'b0;
		end else begin
			serialStart <= 1'b0;
			if (rxValid) begin
				cmdState <= arh_pkg::CMD_IDLE;
				case (cmdState)
					arh_pkg::CMD_IDLE: begin
						if (rxData == arh_pkg::CHR_START) begin
							cmdState <= arh_pkg::CMD_COMMA;
						end
					end
					arh_pkg::CMD_COMMA: begin
						if (rxData == arh_pkg::CHR_COMMA) begin
							cmdState <= arh_pkg::CMD_TENS;
						end
					end
					arh_pkg::CMD_TENS: begin
						if (isDigit(rxData)) begin
							tensChar <= rxData;
							cmdState <= arh_pkg::CMD_ONES;
						end
					end
					arh_pkg::CMD_ONES: begin
						// recipes above 7 do not exist; such a command is dropped
						if (isDigit(rxData) && tensChar == arh_pkg::CHR_ZERO &&
							rxData[2:0] <= arh_pkg::RECIPE_MAX && rxData[7:3] == 5'h06) begin
							cmdRecipe <= rxData[2:0];
							serialStart <= (opMode == arh_pkg::MODE_COMPUTER);
						end
					end
					default: begin
						cmdState <= arh_pkg::CMD_IDLE;
					end
				endcase
			end
		end
	end

	// requests wait here while another report is being queued
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resPend <= 1'b0;
			idPend <= 1'b0;
		end else begin
			resPend <= (resPend && !launchRes) ||
				(rxValid && cmdState == arh_pkg::CMD_IDLE && rxData == arh_pkg::CHR_RESULTS);
			idPend <= (idPend && !launchId) ||
				(rxValid && cmdState == arh_pkg::CMD_IDLE && rxData == arh_pkg::CHR_IDENT);
		end
	end

	// ***************
	// report generator
	// ***************
	assign launchAuto = (state == arh_pkg::ST_REPORT) && (rptKind == arh_pkg::RPT_NONE) && !rptAuto;
	assign launchRes = (rptKind == arh_pkg::RPT_NONE) && !launchAuto && resPend;
	assign launchId = (rptKind == arh_pkg::RPT_NONE) && !launchAuto && !resPend && idPend;
	assign rptLast = (rptKind == arh_pkg::RPT_RESULTS) ? (rptIdx == RES_LAST) : (rptIdx == ID_LAST);
	assign rptEnd = pushS.valid && pushS.ready && rptLast;
	assign pushS.valid = (rptKind != arh_pkg::RPT_NONE);

	always_comb begin
		pushS.data = arh_pkg::CHR_EOF;
		if (rptKind == arh_pkg::RPT_RESULTS && rptIdx < RES_LAST) begin
			pushS.data = resultHold[rptIdx[IW-2:0]];
		end else if (rptKind == arh_pkg::RPT_IDENT && rptIdx == '0) begin
			pushS.data = IDENT_CODE;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rptKind <= arh_pkg::RPT_NONE;
			rptIdx <= '0;
			rptAuto <= 1'b0;
		end else if (rptKind == arh_pkg::RPT_NONE) begin
			rptIdx <= '0;
			if (launchAuto || launchRes) begin
				rptKind <= arh_pkg::RPT_RESULTS;
			end else if (launchId) begin
				rptKind <= arh_pkg::RPT_IDENT;
			end
			rptAuto <= launchAuto;
		end else if (pushS.ready) begin
			rptIdx <= rptIdx + 1'b1;
			if (rptLast) begin
				rptKind <= arh_pkg::RPT_NONE;
				rptAuto <= 1'b0;
			end
		end
	end
	arh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.inS(pushS),
		.outS(popS)
	);
	arh_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
		.clk(clk),
		.rst_b(rst_b),
		.txIn(popS),
		.rxd(rxd),
		.txd(txd),
		.rxData(rxData),
		.rxValid(rxValid)
	);
	// ***************
	// checks
	// ***************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_autoRefresh;
		state == arh_pkg::ST_REFRESH && opMode != arh_pkg::MODE_COMPUTER;
	endsequence
	sequence s_reportPhase;
		state == arh_pkg::ST_REPORT;
	endsequence
	idle_ready_a: assert property (state == arh_pkg::ST_IDLE |-> readyContact)
		else $error("ready open while idle");
	busy_open_a: assert property (state == arh_pkg::ST_ANALYZE |-> !readyContact)
		else $error("ready closed during analysis");
	recipe_latch_a: assert property (accept && !serialStart |=>
		analysisReq && analysisRecipe == $past(recipeContact))
		else $error("recipe not latched from contacts");
	start_cause_a: assert property (analysisReq |-> $past(accept) && $past(state) == arh_pkg::ST_IDLE)
		else $error("analysis started without a start");
	busy_ignore_a: assert property (startEdge && state != arh_pkg::ST_IDLE |=> !analysisReq)
		else $error("start accepted while busy");
	hold_steady_a: assert property (!$stable(resultHold) |->
		$past(state) == arh_pkg::ST_ANALYZE && $past(analysisDone))
		else $error("held results changed outside completion");
	auto_report_a: assert property (s_autoRefresh |=> s_reportPhase ##0 !readyContact)
		else $error("no unprompted report");
	quiet_mode_a: assert property (state == arh_pkg::ST_REFRESH && opMode == arh_pkg::MODE_COMPUTER |=>
		state == arh_pkg::ST_DONE ##1 readyContact)
		else $error("computer mode report sent unprompted");
	ready_after_a: assert property ($rose(readyContact) |-> $past(state) == arh_pkg::ST_DONE && !rptAuto)
		else $error("ready closed before outputs refreshed");
	eof_tail_a: assert property (pushS.valid && rptLast |-> pushS.data == arh_pkg::CHR_EOF)
		else $error("transmission not ended by end of file");
endmodule
`default_nettype wire

// ===== verification/arh_plc_model.sv
// plant controller and serial terminal model facing the block
`default_nettype none
module arh_plc_model #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic clk,
	input wire logic readyContact,
	input wire logic txd,
	output logic startContact,
	output logic [arh_pkg::RECIPE_W-1:0] recipeContact,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rxq[$];
	logic [7:0] sh;
	initial begin
		startContact = 1'b0;
		recipeContact = 3'h0;
		rxd = 1'b1;
	end
	// ***************
	// contacts
	// ***************
	// anyTime breaks the ready rule on purpose, only when a test asks for it
	task automatic press_start(input logic [2:0] r, input logic anyTime);
		@(posedge clk);
		#1 recipeContact = r;
		@(posedge clk);
		#1 if (readyContact || anyTime) startContact = 1'b1;
	endtask
	task automatic release_start();
		@(posedge clk);
		#1 startContact = 1'b0;
	endtask
	// ***************
	// serial
	// ***************
	// 8N1, lsb first, line idles high between frames
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			#1 rxd = f[i];
			repeat (BIT_CYCLES - 1) @(posedge clk);
		end
	endtask
	// a bad stop bit stores the inverted byte so the bench sees it
	initial forever begin
		@(negedge txd);
		repeat (BIT_CYCLES / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clk);
			sh[i] = txd;
		end
		repeat (BIT_CYCLES) @(posedge clk);
		rxq.push_back(txd ? sh : ~sh);
	end
endmodule
`default_nettype wire

// ===== verification/arh_remote_handshake_tb.sv
// self-checking bench of the remote handshake block
`default_nettype none
module arh_remote_handshake_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BITC = 8;
	localparam int DWELL = 4;
	// identity byte handed to the block: value is arbitrary
	localparam logic [7:0] IDENT = 8'h3C;
	logic clk, rst_b, startContact, analysisDone, rxd;
	logic readyContact, analysisReq, analogSlot, txd;
	logic [2:0] recipeContact, analysisRecipe;
	arh_pkg::arh_mode_type opMode;
	logic [7:0][7:0] analysisResult;
	logic [3:0][7:0] analogOut;
	int n_errors, check_count, cycles, reqCount;
	arh_remote_handshake #(.BIT_CYCLES(BITC), .MUX_DWELL_CYCLES(DWELL), .IDENT_CODE(IDENT)) u_arh_remote_handshake (
		.clk(clk), .rst_b(rst_b), .startContact(startContact), .recipeContact(recipeContact),
		.opMode(opMode), .analysisDone(analysisDone), .analysisResult(analysisResult), .rxd(rxd),
		.readyContact(readyContact), .analysisReq(analysisReq), .analysisRecipe(analysisRecipe),
		.analogOut(analogOut), .analogSlot(analogSlot), .txd(txd));
	arh_plc_model #(.BIT_CYCLES(BITC)) u_arh_plc_model (.clk(clk), .readyContact(readyContact),
		.txd(txd), .startContact(startContact), .recipeContact(recipeContact), .rxd(rxd));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ***************
	// helpers
	// ***************
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// the hang guard counts as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (analysisReq === 1'b1) reqCount++;
		if (cycles == 30000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic finish_analysis(input logic [7:0] base);
		repeat (5) @(posedge clk);
		#1;
		for (int k = 0; k < 8; k++) analysisResult[k] = base + 8'(k);
		analysisDone = 1'b1;
		@(posedge clk);
		#1 analysisDone = 1'b0;
	endtask
	// looks at both slots of the multiplex
	task automatic check_analog(input logic [7:0] base);
		logic s;
		int w;
		for (int n = 0; n < 2; n++) begin
			s = analogSlot;
			w = 0;
			while (analogSlot === s) begin
				@(negedge clk);
				w++;
			end
			// the second slot is watched from one cycle after its toggle, so only DWELL - 1 cycles of it remain
			if (n == 1) check(w, DWELL - 1);
			@(negedge clk);
			for (int k = 0; k < 4; k++) check(analogOut[k], base + 8'(k) + (analogSlot ? 8'h04 : 8'h00));
		end
	endtask
	task automatic expect_bytes(input int n, input logic [7:0] base);
		for (int t = 0; t < n * 100 && u_arh_plc_model.rxq.size() < n; t++) @(negedge clk);
		check(u_arh_plc_model.rxq.size(), n);
		for (int k = 0; k < n && k < u_arh_plc_model.rxq.size(); k++)
			check(u_arh_plc_model.rxq[k], k == n - 1 ? arh_pkg::CHR_EOF : base + 8'(k));
		u_arh_plc_model.rxq.delete();
	endtask
	task automatic wait_ready();
		for (int t = 0; t < 50 && readyContact !== 1'b1; t++) @(negedge clk);
		check(readyContact, 1'b1);
	endtask
	// ***************
	// scenarios
	// ***************
	task automatic test_reset();
		@(negedge clk);
		check({readyContact, txd, analysisReq, analogOut}, {2'b11, 33'h0});
		repeat (20) @(negedge clk);
		check(reqCount, 0);
		$display("test_reset done");
	endtask
	// every recipe code, local and remote alternating, restart ignored while busy
	task automatic test_recipes();
		int c;
		for (int r = 0; r < 8; r++) begin
			@(posedge clk) #1 opMode = r[0] ? arh_pkg::MODE_REMOTE : arh_pkg::MODE_LOCAL;
			u_arh_plc_model.press_start(3'(r), 1'b0);
			@(posedge clk);
			#1 check({analysisReq, readyContact, analysisRecipe}, {2'b10, 3'(r)});
			@(posedge clk);
			#1 check(analysisReq, 1'b0);
			u_arh_plc_model.release_start();
			c = reqCount;
			u_arh_plc_model.press_start(3'(r) ^ 3'h7, 1'b1);
			repeat (10) @(negedge clk);
			check({reqCount, readyContact, analysisRecipe}, {c, 1'b0, 3'(r)});
			u_arh_plc_model.release_start();
			if (r > 0) check_analog(8'(r) * 8'h10);
			finish_analysis(8'(r + 1) * 8'h10);
			wait_ready();
			check_analog(8'(r + 1) * 8'h10);
			expect_bytes(9, 8'(r + 1) * 8'h10);
		end
		$display("test_recipes done");
	endtask
	task automatic test_computer();
		int c;
		@(posedge clk) #1 opMode = arh_pkg::MODE_COMPUTER;
		u_arh_plc_model.press_start(3'h5, 1'b0);
		@(posedge clk);
		#1 check({analysisReq, analysisRecipe}, 4'hD);
		u_arh_plc_model.release_start();
		finish_analysis(8'hA0);
		@(posedge clk);
		#1 check(readyContact, 1'b0);
		@(posedge clk);
		#1 check(readyContact, 1'b1);
		repeat (200) @(negedge clk);
		check(u_arh_plc_model.rxq.size(), 0);
		check_analog(8'hA0);
		u_arh_plc_model.send_byte(8'h52);
		repeat (200) @(negedge clk);
		check(u_arh_plc_model.rxq.size(), 0);
		u_arh_plc_model.send_byte(arh_pkg::CHR_RESULTS);
		expect_bytes(9, 8'hA0);
		u_arh_plc_model.send_byte(arh_pkg::CHR_IDENT);
		expect_bytes(2, IDENT);
		c = reqCount;
		u_arh_plc_model.send_byte(arh_pkg::CHR_START);
		u_arh_plc_model.send_byte(arh_pkg::CHR_COMMA);
		u_arh_plc_model.send_byte(arh_pkg::CHR_ZERO);
		u_arh_plc_model.send_byte(8'h33);
		for (int t = 0; t < 30 && reqCount == c; t++) @(negedge clk);
		check({reqCount - c, readyContact, analysisRecipe}, {32'd1, 1'b0, 3'h3});
		finish_analysis(8'hC0);
		wait_ready();
		$display("test_computer done");
	endtask
	initial begin
		rst_b = 1'b0;
		analysisDone = 1'b0;
		analysisResult = '0;
		opMode = arh_pkg::MODE_LOCAL;
		n_errors = 0;
		check_count = 0;
		cycles = 0;
		reqCount = 0;
		repeat (6) @(posedge clk);
		#1 rst_b = 1'b1;
		test_reset();
		test_recipes();
		test_computer();
		give_verdict();
	end
endmodule
`default_nettype wire
